// >>> verilog/ebac_pkg.sv
// Purpose: constants for the external bus area configuration bank
// Assumes: byte-wide registers on a plain strobe port
// Notes: offsets are indices into a small local map
package ebac_pkg;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [2:0] OFF_WIDTH = 3'h0;
  localparam logic [2:0] OFF_ASTATE = 3'h1;
  localparam logic [2:0] OFF_WAIT_HI = 3'h2;
  localparam logic [2:0] OFF_WAIT_LO = 3'h3;
  localparam logic [2:0] OFF_IDLE_BURST = 3'h4;
  localparam logic [7:0] RST_WIDTH_WIDE = 8'hFF;
  localparam logic [7:0] RST_WIDTH_MODE4 = 8'h00;
  localparam logic [7:0] RST_ASTATE = 8'hFF;
  localparam logic [7:0] RST_WAIT = 8'hFF;
  localparam logic [7:0] RST_IDLE_BURST = 8'hD0;
  localparam int BIT_IDLE_RR = 7;
  localparam int BIT_IDLE_RW = 6;
  localparam int BIT_BURST_ROM = 5;
  localparam int BIT_BURST_LEN = 4;
  localparam int BIT_BURST_WORDS = 3;
  localparam logic [1:0] STATES_TWO = 2'h2;
  localparam logic [1:0] STATES_THREE = 2'h3;
  localparam logic [1:0] BURST_STATES_ONE = 2'h1;
  localparam logic [1:0] BURST_STATES_TWO = 2'h2;
  localparam logic [3:0] BURST_WORDS_FOUR = 4'h4;
  localparam logic [3:0] BURST_WORDS_EIGHT = 4'h8;
  typedef enum logic [2:0] {
    EBAC_ACC_INTERNAL = 3'b001,
    EBAC_ACC_BASIC = 3'b010,
    EBAC_ACC_BURST = 3'b100
  } ebac_acc_t;
endpackage : ebac_pkg

// >>> verilog/ebac_area_decode.sv
// Purpose: per-area access shaping for one external access
// Assumes: area index and space kind are valid in the same cycle
// Notes: purely combinational
`timescale 1ns/1ns
module ebac_area_decode
  import ebac_pkg::*;
(
  input wire logic [7:0] astate_bits,
  input wire logic [15:0] wait_bits,
  input wire logic [7:0] width_bits,
  input wire logic [2:0] area,
  input wire logic normal_mode,
  input wire logic external,
  output logic [1:0] access_states,
  output logic [1:0] wait_states,
  output logic narrow_width
);
  logic [2:0] eff_area;
  logic three_state;

  always_comb begin
    eff_area = normal_mode ? 3'h0 : area; // [R3] [R8]
    three_state = astate_bits[eff_area]; // [R1]
    narrow_width = external & width_bits[eff_area]; // [R17]
    if (!external) begin
      access_states = STATES_TWO; // [R2]
      wait_states = 2'h0; // [R7]
    end else if (three_state) begin
      access_states = STATES_THREE;
      wait_states = wait_bits[{eff_area, 1'b0} +: 2]; // [R5] [R6]
    end else begin
      access_states = STATES_TWO;
      wait_states = 2'h0; // [R1]
    end
  end
endmodule : ebac_area_decode

// >>> verilog/ebac_config_bank.sv
// Contract
// R1 - access-state bit 0: two states, no waits; 1: three states, waits allowed
// R2 - access-state settings affect external space only
// R3 - normal mode uses only the area 0 access-state bit
// R4 - access-state and wait registers reset to all ones, kept on soft reset
// R5 - two-bit wait field gives zero to three waits, in three-state mode only
// R6 - wait fields packed two per area, high area in high bits
// R7 - no program waits on internal memory or registers
// R8 - normal mode uses only the area 0 wait field
// R9 - bit 7 inserts idle between reads to different areas
// R10 - bit 6 inserts idle between read and following write
// R11 - bit 5 selects burst ROM interface for area 0
// R12 - software never enables burst ROM and pseudo-static RAM burst together
// R13 - bit 4 selects burst cycle of one or two states
// R14 - bit 3 limits burst to four or eight words
// R15 - idle and burst register resets to D0, kept on soft reset
// R16 - software writes zero to idle and burst register bits 2 to 0
// R17 - width bit 0 gives sixteen bits, 1 gives eight bits; burst ROM accesses always report sixteen bits
// R18 - every bit reads back last written or reset value
//
// Purpose: configuration bank shaping external bus cycles per area
// Assumes: reset_n is power-on or hardware standby; manual reset does not reach it
// Notes: access descriptor is presented one cycle per access
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module ebac_config_bank
  import ebac_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic mode4_strap,
  input wire logic normal_mode,
  input wire logic [ebac_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [ebac_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ebac_pkg::DATA_W-1:0] reg_rdata,
  input wire logic acc_valid,
  input wire logic acc_external,
  input wire logic acc_write,
  input wire logic [2:0] acc_area,
  output logic [1:0] acc_states,
  output logic [1:0] acc_waits,
  output logic acc_narrow,
  output logic acc_idle,
  output logic acc_burst,
  output logic [1:0] burst_states,
  output logic [3:0] burst_words
);
  import ebac_pkg::*;

  logic [7:0] width_r;
  logic [7:0] astate_r;
  logic [7:0] wait_hi_r;
  logic [7:0] wait_lo_r;
  logic [7:0] idle_burst_r;
  logic width_loaded_r;
  logic last_valid_r;
  logic last_read_r;
  logic [2:0] last_area_r;
  logic [7:0] rdata_nxt;
  logic [1:0] states_nxt;
  logic [1:0] waits_nxt;
  logic narrow_nxt;
  logic idle_nxt;
  logic burst_nxt;
  logic [2:0] eff_area;
  logic [15:0] wait_all;
  ebac_acc_t kind;

  assign wait_all = {wait_hi_r, wait_lo_r};

  function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
    hit = (a == off);
  endfunction : hit

  // register writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      astate_r <= RST_ASTATE; // [R4]
      wait_hi_r <= RST_WAIT; // [R4]
      wait_lo_r <= RST_WAIT;
      idle_burst_r <= RST_IDLE_BURST; // [R15]
    end else if (reg_wr) begin
      if (hit(reg_addr, OFF_ASTATE)) astate_r <= reg_wdata; // [R18]
      if (hit(reg_addr, OFF_WAIT_HI)) wait_hi_r <= reg_wdata;
      if (hit(reg_addr, OFF_WAIT_LO)) wait_lo_r <= reg_wdata;
      if (hit(reg_addr, OFF_IDLE_BURST)) idle_burst_r <= reg_wdata; // [R16] stored as written
    end
  end

  // width register; mode strap caught on first edge after release
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      width_r <= RST_WIDTH_WIDE;
      width_loaded_r <= 1'b0;
    end else if (reg_wr && hit(reg_addr, OFF_WIDTH)) begin
      width_r <= reg_wdata;
      width_loaded_r <= 1'b1;
    end else if (!width_loaded_r) begin
      width_r <= mode4_strap ? RST_WIDTH_MODE4 : RST_WIDTH_WIDE;
      width_loaded_r <= 1'b1;
    end
  end

  // read mux
  always_comb begin
    case (reg_addr)
      OFF_WIDTH: rdata_nxt = width_r;
      OFF_ASTATE: rdata_nxt = astate_r;
      OFF_WAIT_HI: rdata_nxt = wait_hi_r;
      OFF_WAIT_LO: rdata_nxt = wait_lo_r;
      OFF_IDLE_BURST: rdata_nxt = idle_burst_r;
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= rdata_nxt; // [R18]
    else reg_rdata <= 8'h00;
  end

  // per-area shaping
  ebac_area_decode u_dec (
    .astate_bits(astate_r),
    .wait_bits({wait_hi_r, wait_lo_r}),
    .width_bits(width_r),
    .area(acc_area),
    .normal_mode(normal_mode),
    .external(acc_external),
    .access_states(states_nxt),
    .wait_states(waits_nxt),
    .narrow_width(narrow_nxt)
  );

  always_comb begin
    eff_area = normal_mode ? 3'h0 : acc_area;
    burst_nxt = acc_external && eff_area == 3'h0 && idle_burst_r[BIT_BURST_ROM]; // [R11]
    if (!acc_external) kind = EBAC_ACC_INTERNAL;
    else if (burst_nxt) kind = EBAC_ACC_BURST;
    else kind = EBAC_ACC_BASIC;
    idle_nxt = 1'b0;
    case (kind)
      EBAC_ACC_INTERNAL: idle_nxt = 1'b0;
      EBAC_ACC_BASIC, EBAC_ACC_BURST: begin
        if (last_valid_r && last_read_r && !acc_write && last_area_r != eff_area)
          idle_nxt = idle_burst_r[BIT_IDLE_RR]; // [R9]
        if (last_valid_r && last_read_r && acc_write)
          idle_nxt = idle_burst_r[BIT_IDLE_RW]; // [R10]
      end
      default: idle_nxt = 1'b0;
    endcase
  end

  // history of previous external cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      last_valid_r <= 1'b0;
      last_read_r <= 1'b0;
      last_area_r <= 3'h0;
    end else if (acc_valid && acc_external) begin
      last_valid_r <= 1'b1;
      last_read_r <= !acc_write;
      last_area_r <= eff_area;
    end else if (acc_valid) begin
      last_valid_r <= 1'b0;
    end
  end

  // registered access descriptor
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_states <= STATES_TWO;
      acc_waits <= 2'h0;
      acc_narrow <= 1'b0;
      acc_idle <= 1'b0;
      acc_burst <= 1'b0;
    end else if (acc_valid) begin
      acc_states <= states_nxt; // [R1] [R2] [R3]
      acc_waits <= waits_nxt; // [R5] [R7] [R8]
      acc_narrow <= narrow_nxt && !burst_nxt; // [R17]
      acc_idle <= idle_nxt;
      acc_burst <= burst_nxt;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      burst_states <= BURST_STATES_TWO;
      burst_words <= BURST_WORDS_FOUR;
    end else begin
      burst_states <= idle_burst_r[BIT_BURST_LEN] ? BURST_STATES_TWO : BURST_STATES_ONE; // [R13]
      burst_words <= idle_burst_r[BIT_BURST_WORDS] ? BURST_WORDS_EIGHT : BURST_WORDS_FOUR; // [R14]
    end
  end

  // assertions
  wait_zero_two_a: assert property (@(posedge clk) disable iff (!reset_n) // [R1]
    acc_valid && states_nxt == STATES_TWO |=> acc_waits == 2'h0)
    else $error("waits with two-state access");
  internal_plain_a: assert property (@(posedge clk) disable iff (!reset_n) // [R2]
    acc_valid && !acc_external |=> acc_states == STATES_TWO && !acc_burst)
    else $error("internal access shaped");
  normal_area0_a: assert property (@(posedge clk) disable iff (!reset_n) // [R3]
    acc_valid && acc_external && normal_mode |=> acc_states == ($past(astate_r[0]) ? STATES_THREE : STATES_TWO))
    else $error("normal mode not area 0 state");
  wait_field_a: assert property (@(posedge clk) disable iff (!reset_n) // [R5]
    acc_valid && acc_external && !normal_mode && astate_r[acc_area]
    |=> acc_waits == $past(wait_all[{acc_area, 1'b0} +: 2]))
    else $error("wait field mismatch");
  internal_nowait_a: assert property (@(posedge clk) disable iff (!reset_n) // [R7]
    acc_valid && !acc_external |=> acc_waits == 2'h0)
    else $error("waits on internal access");
  normal_wait_a: assert property (@(posedge clk) disable iff (!reset_n) // [R8]
    acc_valid && acc_external && normal_mode && astate_r[0] |=> acc_waits == $past(wait_lo_r[1:0]))
    else $error("normal mode wait not area 0");
  sequence read_then_other_read;
    last_valid_r && last_read_r ##0
      acc_valid && acc_external && !acc_write && last_area_r != eff_area;
  endsequence
  idle_read_a: assert property (@(posedge clk) disable iff (!reset_n) // [R9]
    read_then_other_read |=> acc_idle == $past(idle_burst_r[BIT_IDLE_RR]))
    else $error("read-read idle wrong");
  sequence read_then_write;
    last_valid_r && last_read_r ##0 acc_valid && acc_external && acc_write;
  endsequence
  idle_write_a: assert property (@(posedge clk) disable iff (!reset_n) // [R10]
    read_then_write |=> acc_idle == $past(idle_burst_r[BIT_IDLE_RW]))
    else $error("read-write idle wrong");
  burst_len_a: assert property (@(posedge clk) disable iff (!reset_n) // [R13]
    ##1 burst_states == ($past(idle_burst_r[BIT_BURST_LEN]) ? BURST_STATES_TWO : BURST_STATES_ONE))
    else $error("burst length wrong");
  readback_a: assert property (@(posedge clk) disable iff (!reset_n) // [R18]
    reg_wr && hit(reg_addr, OFF_ASTATE) ##1 reg_rd && hit(reg_addr, OFF_ASTATE) && !reg_wr
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("readback mismatch");
endmodule : ebac_config_bank

// >>> test/ebac_acc_src.sv
// Purpose: requester model for the access descriptor port
// Assumes: one descriptor per call, taken on one edge
// Notes: released fields show the inverse of their last value
`timescale 1ns/1ns
module ebac_acc_src (
  input wire logic clk,
  output logic acc_valid,
  output logic acc_external,
  output logic acc_write,
  output logic [2:0] acc_area
);
  initial begin
    acc_valid = 1'b0;
    acc_external = 1'b0;
    acc_write = 1'b0;
    acc_area = 3'h0;
  end
  task automatic issue(input logic ext, input logic wr, input logic [2:0] area);
    @(posedge clk);
    acc_valid <= 1'b1;
    acc_external <= ext;
    acc_write <= wr;
    acc_area <= area;
    @(posedge clk);
    acc_valid <= 1'b0;
    acc_external <= ~ext;
    acc_write <= ~wr;
    acc_area <= ~area;
    #1;
  endtask : issue
endmodule : ebac_acc_src

// >>> test/external_bus_area_config_test.sv
// Purpose: register and access checks of the area configuration bank
// Assumes: reset_n stands for power-on reset only
// Notes: software never sets pseudo-static RAM burst
`timescale 1ns/1ns
module external_bus_area_config_test;
  import ebac_pkg::*;
  logic clk = 1'b0;
  logic reset_n, mode4_strap, normal_mode, reg_wr, reg_rd;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic acc_valid, acc_external, acc_write, acc_narrow, acc_idle, acc_burst;
  logic [2:0] acc_area;
  logic [1:0] acc_states, acc_waits, burst_states;
  logic [3:0] burst_words;
  logic [15:0] wt = 16'hE41B;
  int errors = 0;
  int n_checks = 0;
  always #50 clk = ~clk;
  ebac_config_bank dut (.clk(clk), .reset_n(reset_n), .mode4_strap(mode4_strap), .normal_mode(normal_mode),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .acc_valid(acc_valid), .acc_external(acc_external), .acc_write(acc_write), .acc_area(acc_area),
    .acc_states(acc_states), .acc_waits(acc_waits), .acc_narrow(acc_narrow), .acc_idle(acc_idle),
    .acc_burst(acc_burst), .burst_states(burst_states), .burst_words(burst_words));
  ebac_acc_src src (.clk(clk), .acc_valid(acc_valid), .acc_external(acc_external), .acc_write(acc_write),
    .acc_area(acc_area));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic wr_rd_chk(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, d);
  endtask : wr_rd_chk
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rd_chk
  task automatic rst(input logic strap);
    reset_n <= 1'b0;
    mode4_strap <= strap;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : rst
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict
  initial begin
    #500000;
    errors++;
    give_verdict();
  end
  initial begin
    reset_n = 1'b0;
    mode4_strap = 1'b0;
    normal_mode = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rst(1'b0);
    rd_chk(3'h0, 8'hFF);
    rd_chk(3'h1, 8'hFF);
    rd_chk(3'h2, 8'hFF);
    rd_chk(3'h3, 8'hFF);
    rd_chk(3'h4, 8'hD0);
    $display("test reset done");
    wr(3'h0, 8'h3C);
    wr_rd_chk(3'h1, 8'h55);
    wr(3'h2, 8'hE4);
    wr(3'h3, 8'h1B);
    wr(3'h4, 8'hC8);
    wr(3'h5, 8'hFF);
    rd_chk(3'h5, 8'h00);
    rd_chk(3'h0, 8'h3C);
    rd_chk(3'h1, 8'h55);
    rd_chk(3'h2, 8'hE4);
    rd_chk(3'h3, 8'h1B);
    rd_chk(3'h4, 8'hC8);
    $display("test readback done");
    for (int a = 0; a < 8; a++) begin
      src.issue(1'b1, 1'b0, 3'(a));
      chk({6'h00, acc_states}, (a % 2 == 0) ? 8'h03 : 8'h02);
      chk({6'h00, acc_waits}, (a % 2 == 0) ? {6'h00, wt[2*a +: 2]} : 8'h00);
      chk({7'h00, acc_narrow}, (8'h3C >> a) & 8'h01);
      if (a > 0) chk({7'h00, acc_idle}, 8'h01);
    end
    src.issue(1'b0, 1'b0, 3'h0);
    chk({6'h00, acc_waits}, 8'h00);
    $display("test areas done");
    @(posedge clk) normal_mode <= 1'b1;
    src.issue(1'b1, 1'b0, 3'h5);
    chk({6'h00, acc_states}, 8'h03);
    chk({6'h00, acc_waits}, 8'h03);
    chk({7'h00, acc_narrow}, 8'h00);
    wr(3'h1, 8'h54);
    src.issue(1'b1, 1'b0, 3'h6);
    chk({6'h00, acc_states}, 8'h02);
    chk({6'h00, acc_waits}, 8'h00);
    @(posedge clk) normal_mode <= 1'b0;
    $display("test normal mode done");
    src.issue(1'b1, 1'b0, 3'h1);
    src.issue(1'b1, 1'b0, 3'h1);
    chk({7'h00, acc_idle}, 8'h00);
    src.issue(1'b1, 1'b1, 3'h1);
    chk({7'h00, acc_idle}, 8'h01);
    wr(3'h4, 8'h00);
    src.issue(1'b1, 1'b0, 3'h2);
    src.issue(1'b1, 1'b0, 3'h3);
    chk({7'h00, acc_idle}, 8'h00);
    src.issue(1'b1, 1'b1, 3'h3);
    chk({7'h00, acc_idle}, 8'h00);
    $display("test idle done");
    wr(3'h4, 8'h20);
    src.issue(1'b1, 1'b0, 3'h0);
    chk({7'h00, acc_burst}, 8'h01);
    chk({6'h00, burst_states}, 8'h01);
    chk({4'h0, burst_words}, 8'h04);
    src.issue(1'b1, 1'b0, 3'h3);
    chk({7'h00, acc_burst}, 8'h00);
    wr(3'h4, 8'h38);
    @(posedge clk) normal_mode <= 1'b1;
    src.issue(1'b1, 1'b0, 3'h3);
    chk({7'h00, acc_burst}, 8'h01);
    chk({6'h00, burst_states}, 8'h02);
    chk({4'h0, burst_words}, 8'h08);
    $display("test burst done");
    rst(1'b1);
    rd_chk(3'h0, 8'h00);
    rd_chk(3'h1, 8'hFF);
    rd_chk(3'h3, 8'hFF);
    rd_chk(3'h4, 8'hD0);
    $display("test second reset done");
    give_verdict();
  end
endmodule : external_bus_area_config_test
